// file: rtl/fir_cfg.svh
// ---------------------------------------------------------------
// constants for the decimating ram fir stage and its host end
// ---------------------------------------------------------------
// definitions only; included by bare name wherever needed
`ifndef FIR_CFG_SVH
`define FIR_CFG_SVH

// register select codes on the host port
`define FIR_REG_TAPS 3'h0
`define FIR_REG_OFF 3'h1
`define FIR_REG_CTRL 3'h2
`define FIR_REG_START 3'h3
`define FIR_REG_STOP 3'h4
`define FIR_REG_MEM 3'h5

// control register fields
`define FIR_DEC_RNG 3:0
`define FIR_PH_RNG 7:4
`define FIR_SCALE_RNG 9:8
`define FIR_SYM_BIT 10
`define FIR_BYP_BIT 11
`define FIR_CTRL_RST 16'h0300

// arithmetic and timing
`define FIR_COEF_FRAC 13
`define FIR_SCALE_MAX 3
`define FIR_FAST_CLK_MHZ 200
`define FIR_BYTE_W 8
`define FIR_PORT_W 16
`define FIR_SEL_W 3

`endif

// file: rtl/fir_pkg.sv
// ---------------------------------------------------------------
// shared types for the fir stage and its host end
// ---------------------------------------------------------------
// no dependencies
package fir_pkg;
  typedef enum {ST_IDLE, ST_MAC, ST_PUSH} fir_state_t;
  typedef enum {H_IDLE, H_BYTE2, H_WAIT, H_PROG} host_state_t;
  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_PROGRAM} host_op_t;
endpackage : fir_pkg

// file: rtl/fir_reg_if.sv
// ---------------------------------------------------------------
// host port between the configuring party and the fir stage
// ---------------------------------------------------------------
// both ends run on one clock; the bench instantiates and joins
`timescale 1ns/1ps
`include "fir_cfg.svh"
interface fir_reg_if;
  logic reg_wr;
  logic reg_rd;
  logic [`FIR_SEL_W-1:0] reg_addr;
  logic [`FIR_PORT_W-1:0] reg_wdata;
  logic reg_byte_mode;
  logic [`FIR_PORT_W-1:0] reg_rdata;
  logic reg_rvalid;
  modport host (output reg_wr, reg_rd, reg_addr, reg_wdata,
    reg_byte_mode, input reg_rdata, reg_rvalid);
  modport device (input reg_wr, reg_rd, reg_addr, reg_wdata,
    reg_byte_mode, output reg_rdata, reg_rvalid);
endinterface : fir_reg_if

// file: rtl/decimating_ram_fir.sv
// ---------------------------------------------------------------
// decimating ram coefficient fir stage, i/q, one mac per path
// ---------------------------------------------------------------
// assumes sys_clk is the fast processing clock and that samples
// arrive from the helper filter with valid/ready on this clock
`timescale 1ns/1ps
`include "fir_cfg.svh"
module decimating_ram_fir #(
  parameter int SW = 20,
  parameter int CW = 14,
  parameter int CD = 64
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  fir_reg_if.device link,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [SW-1:0] in_i,
  input wire logic [SW-1:0] in_q,
  output logic out_valid,
  input wire logic out_ready,
  output logic [SW-1:0] out_i,
  output logic [SW-1:0] out_q
);
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int AW = $clog2(CD);
  localparam int HD = 2 * CD;
  localparam int TW = $clog2(HD);
  localparam int PW = SW + 1 + CW;
  localparam int AccW = PW + TW;
  localparam int FAST_MHZ = `FIR_FAST_CLK_MHZ;
  localparam logic signed [AccW-1:0] SMAX = AccW'(2 ** (SW - 1) - 1);
  localparam logic signed [AccW-1:0] SMIN = -SMAX - AccW'(1);

  // byte assembly needs a coefficient wider than one byte
  if (CW <= `FIR_BYTE_W || CW > `FIR_PORT_W || CD < 2 ||
      (1 << AW) != CD || SW < 2) begin : g_bad
    $error("decimating_ram_fir: unsupported parameters");
  end

  typedef struct packed {
    fir_pkg::fir_state_t st;
    logic [TW-1:0] taps;
    logic [AW-1:0] off;
    logic [AW-1:0] start;
    logic [AW-1:0] stop;
    logic [AW-1:0] ptr;
    logic [15:0] ctrl;
    logic [`FIR_BYTE_W-1:0] low;
    logic low_have;
    logic rd_high;
    logic [15:0] rdata;
    logic rvalid;
    logic [CD-1:0][CW-1:0] ram;
    logic [HD-1:0][2*SW-1:0] hist;
    logic [TW-1:0] wp;
    logic [TW-1:0] k;
    logic [TW-1:0] job_taps;
    logic [AW-1:0] job_off;
    logic job_sym;
    logic [1:0] job_scale;
    logic [3:0] ph_cnt;
    logic signed [AccW-1:0] acc_i;
    logic signed [AccW-1:0] acc_q;
    logic [1:0][2*SW-1:0] slot;
    logic [1:0] fcnt;
    logic in_ready;
    logic out_valid;
  } state_t;

  state_t q;
  state_t d;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // pointer walk shared by reads and writes of the memory register
  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p,
      input logic [AW-1:0] s, input logic [AW-1:0] e);
    return (p == e) ? s : p + AW'(1);
  endfunction : ptr_next

  // drop fraction bits, attenuate by 6 dB steps, saturate to SW
  function automatic logic [SW-1:0] scale_sat(
      input logic signed [AccW-1:0] a, input logic [1:0] sc);
    logic signed [AccW-1:0] s;
    s = a >>> (`FIR_COEF_FRAC + `FIR_SCALE_MAX - int'(sc));
    if (s > SMAX) return SMAX[SW-1:0];
    if (s < SMIN) return SMIN[SW-1:0];
    return s[SW-1:0];
  endfunction : scale_sat

  function automatic logic signed [SW:0] sx(input logic [SW-1:0] v);
    return {v[SW-1], v};
  endfunction : sx

  // ---------------------------------------------------------------
  // tap address generation
  // ---------------------------------------------------------------
  logic [TW-1:0] half;
  logic [TW-1:0] ta;
  logic [TW-1:0] tb;
  logic [TW-1:0] ia;
  logic [TW-1:0] ib;
  logic single;
  logic last_tap;
  logic signed [SW:0] xi;
  logic signed [SW:0] xq;
  logic signed [CW-1:0] cf;
  logic signed [PW-1:0] pi;
  logic signed [PW-1:0] pq;

  // folded mode pairs x[n-a] with x[n-(N-1-a)] under one coefficient
  always_comb begin
    half = TW'(({1'b0, q.job_taps} + (TW+1)'(1)) >> 1);
    ta = half + q.k;
    tb = q.job_taps - ta;
    if (q.job_sym) begin
      ia = q.wp - ta;
      ib = q.wp - tb;
      single = (ta == tb);
      last_tap = (q.k == (q.job_taps >> 1));
    end else begin
      ia = q.wp - q.job_taps + q.k;
      ib = ia;
      single = 1'b1;
      last_tap = (q.k == q.job_taps);
    end
    xi = sx(q.hist[ia][2*SW-1:SW]) +
      (single ? '0 : sx(q.hist[ib][2*SW-1:SW]));
    xq = sx(q.hist[ia][SW-1:0]) + (single ? '0 : sx(q.hist[ib][SW-1:0]));
    cf = q.ram[q.job_off + q.k[AW-1:0]];
    pi = xi * cf;
    pq = xq * cf;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic take;
  logic push;
  logic [2*SW-1:0] push_word;
  logic [CW-1:0] cword;

  always_comb begin
    d = q;
    push = 1'b0;
    push_word = '0;
    cword = q.ram[q.ptr];
    d.rvalid = 1'b0;
    take = in_valid && q.in_ready;

    // host writes; address writes reload the ram pointer
    if (link.reg_wr) begin
      case (link.reg_addr)
        `FIR_REG_TAPS: d.taps = link.reg_wdata[TW-1:0];
        `FIR_REG_OFF: d.off = link.reg_wdata[AW-1:0];
        `FIR_REG_CTRL: d.ctrl = link.reg_wdata;
        `FIR_REG_START: begin
          d.start = link.reg_wdata[AW-1:0];
          d.ptr = link.reg_wdata[AW-1:0];
        end
        `FIR_REG_STOP: begin
          d.stop = link.reg_wdata[AW-1:0];
          d.ptr = q.start;
        end
        `FIR_REG_MEM: begin
          if (link.reg_byte_mode && !q.low_have) begin
            d.low = link.reg_wdata[`FIR_BYTE_W-1:0];
            d.low_have = 1'b1;
          end else begin
            // unused upper bits of a wide write are dropped
            d.ram[q.ptr] = link.reg_byte_mode ?
              {link.reg_wdata[CW-`FIR_BYTE_W-1:0], q.low} :
              link.reg_wdata[CW-1:0];
            d.low_have = 1'b0;
            d.ptr = ptr_next(q.ptr, q.start, q.stop);
          end
        end
        default: ;
      endcase
    end

    // host reads answer one clock later
    if (link.reg_rd) begin
      d.rvalid = 1'b1;
      case (link.reg_addr)
        `FIR_REG_TAPS: d.rdata = 16'(q.taps);
        `FIR_REG_OFF: d.rdata = 16'(q.off);
        `FIR_REG_CTRL: d.rdata = q.ctrl;
        `FIR_REG_START: d.rdata = 16'(q.start);
        `FIR_REG_STOP: d.rdata = 16'(q.ptr);
        `FIR_REG_MEM: begin
          if (link.reg_byte_mode && !q.rd_high) begin
            d.rdata = 16'(cword[`FIR_BYTE_W-1:0]);
            d.rd_high = 1'b1;
          end else begin
            d.rdata = link.reg_byte_mode ? 16'(cword[CW-1:`FIR_BYTE_W]) :
              16'(cword);
            d.rd_high = 1'b0;
            d.ptr = ptr_next(q.ptr, q.start, q.stop);
          end
        end
        default: d.rdata = '0;
      endcase
    end

    // sample intake and decimation phase
    if (take) begin
      if (q.ctrl[`FIR_BYP_BIT]) begin
        push = 1'b1;
        push_word = {in_i, in_q};
      end else begin
        d.wp = q.wp + TW'(1);
        d.hist[d.wp] = {in_i, in_q};
        d.ph_cnt = (q.ph_cnt >= q.ctrl[`FIR_DEC_RNG]) ? '0 :
          q.ph_cnt + 4'h1;
        if (q.ph_cnt == q.ctrl[`FIR_PH_RNG]) begin
          // offset and shape are frozen for the whole sample
          d.job_off = q.off;
          d.job_sym = q.ctrl[`FIR_SYM_BIT];
          d.job_scale = q.ctrl[`FIR_SCALE_RNG];
          d.job_taps = (!q.ctrl[`FIR_SYM_BIT] && q.taps > TW'(CD - 1)) ?
            TW'(CD - 1) : q.taps;
          d.k = '0;
          d.acc_i = '0;
          d.acc_q = '0;
          d.st = fir_pkg::ST_MAC;
        end
      end
    end

    case (q.st)
      fir_pkg::ST_IDLE: ;
      fir_pkg::ST_MAC: begin
        d.acc_i = q.acc_i + AccW'(pi);
        d.acc_q = q.acc_q + AccW'(pq);
        d.k = q.k + TW'(1);
        if (last_tap) d.st = fir_pkg::ST_PUSH;
      end
      fir_pkg::ST_PUSH: begin
        // waits here while both buffer slots are full
        if (q.fcnt != 2'h2) begin
          push = 1'b1;
          push_word = {scale_sat(q.acc_i, q.job_scale),
            scale_sat(q.acc_q, q.job_scale)};
          d.st = fir_pkg::ST_IDLE;
        end
      end
      default: d.st = fir_pkg::ST_IDLE;
    endcase

    // two-slot output buffer, slot 0 is always the head
    if (q.out_valid && out_ready) begin
      d.slot[0] = q.slot[1];
      d.fcnt = q.fcnt - 2'h1;
    end
    if (push) begin
      d.slot[d.fcnt[0]] = push_word;
      d.fcnt = d.fcnt + 2'h1;
    end
    d.out_valid = (d.fcnt != 2'h0);
    // intake only when idle with room, so bypass never overflows
    d.in_ready = (d.st == fir_pkg::ST_IDLE) && (d.fcnt != 2'h2);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.ctrl <= `FIR_CTRL_RST;
    end else begin
      q <= d;
    end
  end

  assign in_ready = q.in_ready;
  assign out_valid = q.out_valid;
  assign out_i = q.slot[0][2*SW-1:SW];
  assign out_q = q.slot[0][SW-1:0];
  assign link.reg_rdata = q.rdata;
  assign link.reg_rvalid = q.rvalid;
endmodule : decimating_ram_fir

// file: rtl/fir_host_end.sv
// ---------------------------------------------------------------
// host end: register access and filter setup over the host port
// ---------------------------------------------------------------
// assumes the fir stage answers a read one clock after it
`timescale 1ns/1ps
`include "fir_cfg.svh"
module fir_host_end (
  input wire logic sys_clk,
  input wire logic reset_n,
  fir_reg_if.host link,
  input wire logic byte_mode,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire fir_pkg::host_op_t cmd_op,
  input wire logic [`FIR_SEL_W-1:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic [6:0] cmd_taps,
  input wire logic cmd_sym,
  output logic rsp_valid,
  output logic [15:0] rsp_data
);
  typedef struct packed {
    fir_pkg::host_state_t st;
    logic wr;
    logic rd;
    logic [`FIR_SEL_W-1:0] addr;
    logic [15:0] wdata;
    logic [7:0] hi;
    logic [7:0] lo;
    logic split;
    logic bmode;
    logic second;
    logic [15:0] ctrl;
    logic [6:0] taps;
    logic sym;
    logic [2:0] step;
    logic ready;
    logic rvalid;
    logic [15:0] rdata;
  } host_t;

  host_t q;
  host_t d;
  logic [5:0] offv;

  // ---------------------------------------------------------------
  // command sequencing
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.wr = 1'b0;
    d.rd = 1'b0;
    d.rvalid = 1'b0;
    // folded load starts at 64 - floor(N/2), wrapping in 6 bits
    offv = q.sym ? 6'(7'h40 - 7'((q.taps + 7'h1) >> 1)) : 6'h00;
    case (q.st)
      fir_pkg::H_IDLE: begin
        if (cmd_valid && q.ready) begin
          d.addr = cmd_addr;
          d.bmode = byte_mode; // held for the whole byte pair
          d.split = byte_mode && (cmd_addr == `FIR_REG_MEM);
          case (cmd_op)
            fir_pkg::OP_WRITE: begin
              d.wr = 1'b1;
              // byte-mode memory writes send low byte now, high byte next
              d.wdata = d.split ? {8'h00, cmd_data[7:0]} : cmd_data;
              d.hi = cmd_data[15:8];
              if (cmd_addr == `FIR_REG_CTRL) d.ctrl = cmd_data;
              if (d.split) d.st = fir_pkg::H_BYTE2;
            end
            fir_pkg::OP_READ: begin
              d.rd = 1'b1;
              d.second = 1'b0;
              d.st = fir_pkg::H_WAIT;
            end
            fir_pkg::OP_PROGRAM: begin
              d.taps = cmd_taps;
              d.sym = cmd_sym;
              d.step = 3'h0;
              d.st = fir_pkg::H_PROG;
            end
            default: ;
          endcase
        end
      end
      fir_pkg::H_BYTE2: begin
        d.wr = 1'b1;
        d.wdata = {8'h00, q.hi};
        d.st = fir_pkg::H_IDLE;
      end
      fir_pkg::H_WAIT: begin
        if (link.reg_rvalid) begin
          if (q.split && !q.second) begin
            d.lo = link.reg_rdata[7:0];
            d.second = 1'b1;
            d.rd = 1'b1;
          end else begin
            d.rvalid = 1'b1;
            d.rdata = q.second ? {link.reg_rdata[7:0], q.lo} :
              link.reg_rdata;
            d.st = fir_pkg::H_IDLE;
          end
        end
      end
      fir_pkg::H_PROG: begin
        // coefficients follow as ordinary memory writes by the user
        d.wr = 1'b1;
        d.step = q.step + 3'h1;
        case (q.step)
          3'h0: begin
            d.addr = `FIR_REG_TAPS;
            d.wdata = 16'(q.taps);
          end
          3'h1: begin
            d.addr = `FIR_REG_OFF;
            d.wdata = 16'(offv);
          end
          3'h2: begin
            d.addr = `FIR_REG_CTRL;
            d.ctrl[`FIR_SYM_BIT] = q.sym;
            d.wdata = d.ctrl;
          end
          3'h3: begin
            d.addr = `FIR_REG_START;
            d.wdata = 16'(offv);
          end
          default: begin
            d.addr = `FIR_REG_STOP;
            d.wdata = q.sym ? 16'(q.taps >> 1) :
              16'(6'(offv + q.taps[5:0]));
            d.st = fir_pkg::H_IDLE;
          end
        endcase
      end
      default: d.st = fir_pkg::H_IDLE;
    endcase
    d.ready = (d.st == fir_pkg::H_IDLE);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.ctrl <= `FIR_CTRL_RST;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.reg_wr = q.wr;
  assign link.reg_rd = q.rd;
  assign link.reg_addr = q.addr;
  assign link.reg_wdata = q.wdata;
  assign link.reg_byte_mode = q.bmode;
  assign cmd_ready = q.ready;
  assign rsp_valid = q.rvalid;
  assign rsp_data = q.rdata;
endmodule : fir_host_end

// file: tb/fir_link_props.sv
// ---------------------------------------------------------------
// host port checker between host end and fir stage
// ---------------------------------------------------------------
// sees only the link signals; instantiated beside the interface
`timescale 1ns/1ps
`include "fir_cfg.svh"
module fir_link_props (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`FIR_SEL_W-1:0] reg_addr,
  input wire logic [`FIR_PORT_W-1:0] reg_wdata,
  input wire logic reg_byte_mode,
  input wire logic [`FIR_PORT_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  logic [11:0] ctrl_q;
  logic [6:0] taps_q;
  logic [5:0] start_q;
  logic at_start_q;
  logic half_q;

  // shadows of written registers; pointer known only until a mem access
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= 12'h300;
      taps_q <= 7'h0;
      start_q <= 6'h0;
      at_start_q <= 1'b1;
      half_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `FIR_REG_CTRL) ctrl_q <= reg_wdata[11:0];
      if (reg_wr && reg_addr == `FIR_REG_TAPS) taps_q <= reg_wdata[6:0];
      if (reg_wr && reg_addr == `FIR_REG_START) start_q <= reg_wdata[5:0];
      if (reg_wr && (reg_addr == `FIR_REG_START ||
          reg_addr == `FIR_REG_STOP)) at_start_q <= 1'b1;
      else if ((reg_wr || reg_rd) && reg_addr == `FIR_REG_MEM)
        at_start_q <= 1'b0;
      if (reg_wr && reg_addr == `FIR_REG_MEM && reg_byte_mode)
        half_q <= !half_q;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_read_answer; reg_rd |=> reg_rvalid; endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered next cycle");
  property p_no_spurious; !reg_rd |=> !reg_rvalid; endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("read answer without request");
  property p_rdata_hold; !reg_rvalid |-> $stable(reg_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without answer");
  property p_rw_exclusive; !(reg_wr && reg_rd); endproperty
  a_rw_exclusive: assert property (p_rw_exclusive)
    else $error("write and read together");
  property p_wide_upper_zero;
    reg_rd && reg_addr == `FIR_REG_MEM && !reg_byte_mode
      |=> reg_rdata[15:14] == 2'h0;
  endproperty
  a_wide_upper_zero: assert property (p_wide_upper_zero)
    else $error("coefficient upper bits not zero");
  property p_ctrl_readback;
    reg_rd && reg_addr == `FIR_REG_CTRL |=> reg_rdata[11:0] == ctrl_q;
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback)
    else $error("control readback wrong");
  property p_taps_readback;
    reg_rd && reg_addr == `FIR_REG_TAPS |=> reg_rdata[6:0] == taps_q;
  endproperty
  a_taps_readback: assert property (p_taps_readback)
    else $error("tap count readback wrong");
  property p_ptr_reload;
    reg_rd && reg_addr == `FIR_REG_STOP && at_start_q
      |=> reg_rdata[5:0] == start_q;
  endproperty
  a_ptr_reload: assert property (p_ptr_reload)
    else $error("pointer not at start after reload");
  property p_byte_pair;
    reg_wr && reg_addr == `FIR_REG_MEM && reg_byte_mode && !half_q
      |=> reg_wr && reg_addr == `FIR_REG_MEM;
  endproperty
  a_byte_pair: assert property (p_byte_pair)
    else $error("high byte did not follow low byte");
endmodule : fir_link_props

// file: tb/testbench.sv
// ---------------------------------------------------------------
// testbench: host end drives the fir stage over the host port
// ---------------------------------------------------------------
// assumes both design ends, the interface and checker are compiled
`timescale 1ns/1ps
`include "fir_cfg.svh"
module testbench;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic byte_mode = 1'b0;
  logic cmd_valid = 1'b0;
  fir_pkg::host_op_t cmd_op = fir_pkg::OP_WRITE;
  logic [`FIR_SEL_W-1:0] cmd_addr = 3'h0;
  logic [15:0] cmd_data = 16'h0;
  logic [6:0] cmd_taps = 7'h0;
  logic cmd_sym = 1'b0;
  logic in_valid = 1'b0;
  logic [19:0] in_i = 20'h0;
  logic [19:0] in_q = 20'h0;
  logic out_ready = 1'b1;
  logic cmd_ready, rsp_valid, in_ready, out_valid;
  logic [15:0] rsp_data, r;
  logic [19:0] out_i, out_q;
  logic [39:0] outs[$];
  int miscompares = 0;
  int checks_done = 0;
  int x, y, prev;

  fir_reg_if link();
  decimating_ram_fir u_decimating_ram_fir (.sys_clk(sys_clk),
    .reset_n(reset_n), .link(link), .in_valid(in_valid),
    .in_ready(in_ready), .in_i(in_i), .in_q(in_q), .out_valid(out_valid),
    .out_ready(out_ready), .out_i(out_i), .out_q(out_q));
  fir_host_end u_fir_host_end (.sys_clk(sys_clk), .reset_n(reset_n),
    .link(link), .byte_mode(byte_mode), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_taps(cmd_taps), .cmd_sym(cmd_sym),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  fir_link_props u_fir_link_props (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_byte_mode(link.reg_byte_mode),
    .reg_rdata(link.reg_rdata), .reg_rvalid(link.reg_rvalid));

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  // collect every sample the consumer pops, in order
  always @(posedge sys_clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1)
      outs.push_back({out_i, out_q});
  end

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic flag(input string m);
    miscompares++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : flag

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) flag($sformatf("got %h expected %h", got, exp));
  endtask : chk

  // command held until ready is seen before an edge; ready is registered
  task automatic do_cmd(input fir_pkg::host_op_t op,
      input logic [`FIR_SEL_W-1:0] a, input logic [15:0] d,
      input logic [6:0] t, input logic s);
    int n;
    bit got;
    n = 0;
    got = 1'b0;
    @(posedge sys_clk);
    cmd_op <= op;
    {cmd_valid, cmd_addr, cmd_data, cmd_taps, cmd_sym} <= {1'b1, a, d, t, s};
    @(negedge sys_clk);
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    do begin
      @(negedge sys_clk);
      n++;
      if (rsp_valid === 1'b1) begin
        r = rsp_data;
        got = 1'b1;
      end
    end while (n < 50 && !(cmd_ready === 1'b1 &&
        (got || op != fir_pkg::OP_READ)));
    if (n >= 50) flag("host command stuck");
  endtask : do_cmd

  task automatic wr(input logic [`FIR_SEL_W-1:0] a, input logic [15:0] d);
    do_cmd(fir_pkg::OP_WRITE, a, d, 7'h0, 1'b0);
  endtask : wr

  task automatic rd_chk(input logic [`FIR_SEL_W-1:0] a,
      input logic [15:0] e);
    do_cmd(fir_pkg::OP_READ, a, 16'h0, 7'h0, 1'b0);
    chk(40'(r), 40'(e));
  endtask : rd_chk

  task automatic push(input int i, input int q);
    int n;
    n = 0;
    @(posedge sys_clk);
    {in_valid, in_i, in_q} <= {1'b1, 20'(i), 20'(q)};
    @(negedge sys_clk);
    while (in_ready !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 200) flag("sample never taken");
    @(posedge sys_clk);
    in_valid <= 1'b0;
  endtask : push

  task automatic take(input int ei, input int eq);
    int n;
    n = 0;
    while (outs.size() == 0 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    if (outs.size() == 0) flag("no output sample");
    else chk(outs.pop_front(), {20'(ei), 20'(eq)});
  endtask : take

  task automatic final_report;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // run is a few hundred cycles; the limit leaves wide margin
  initial begin
    repeat (20000) @(posedge sys_clk);
    flag("watchdog expired");
    final_report();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd_chk(`FIR_REG_CTRL, 16'h0300);
    rd_chk(`FIR_REG_TAPS, 16'h0000);
    wr(`FIR_REG_TAPS, 16'h0013);
    rd_chk(`FIR_REG_TAPS, 16'h0013);
    wr(`FIR_REG_TAPS, 16'h007f);
    rd_chk(`FIR_REG_TAPS, 16'h007f);
    // one location; the upper port bits must be dropped
    wr(`FIR_REG_START, 16'h0005);
    wr(`FIR_REG_STOP, 16'h0005);
    wr(`FIR_REG_MEM, 16'hfabc);
    rd_chk(`FIR_REG_STOP, 16'h0005);
    rd_chk(`FIR_REG_MEM, 16'h3abc);
    rd_chk(`FIR_REG_STOP, 16'h0005);
    // pointer walks start to stop, then wraps; reads advance it too
    wr(`FIR_REG_START, 16'h0002);
    wr(`FIR_REG_STOP, 16'h0003);
    rd_chk(`FIR_REG_STOP, 16'h0002);
    do_cmd(fir_pkg::OP_READ, `FIR_REG_MEM, 16'h0, 7'h0, 1'b0);
    rd_chk(`FIR_REG_STOP, 16'h0003);
    wr(`FIR_REG_MEM, 16'h0000);
    rd_chk(`FIR_REG_STOP, 16'h0002);
    // byte port: low byte first, word assembled whole
    wr(`FIR_REG_START, 16'h0007);
    wr(`FIR_REG_STOP, 16'h0007);
    @(posedge sys_clk);
    byte_mode <= 1'b1;
    wr(`FIR_REG_MEM, 16'h12a5);
    // byte read: low byte answered first, pointer moves after high
    rd_chk(`FIR_REG_MEM, 16'h12a5);
    @(posedge sys_clk);
    byte_mode <= 1'b0;
    rd_chk(`FIR_REG_MEM, 16'h12a5);
    // two-tap plain filter, coefficients 0.5 and 0.25, last first
    wr(`FIR_REG_CTRL, 16'h0300);
    do_cmd(fir_pkg::OP_PROGRAM, 3'h0, 16'h0, 7'h01, 1'b0);
    wr(`FIR_REG_MEM, 16'h0800);
    wr(`FIR_REG_MEM, 16'h1000);
    push(100, -100);
    take(50, -50);
    push(200, -200);
    take(125, -125);
    push(800, -800);
    take(450, -450);
    for (int s = 0; s < 4; s++) begin
      wr(`FIR_REG_CTRL, 16'(s) << 8);
      push(800, -800);
      take(75 << s, -(75 << s));
    end
    // rate three, phase one: outputs only on inputs 1 and 4
    wr(`FIR_REG_CTRL, 16'h0312);
    prev = 800;
    for (int k = 0; k < 6; k++) begin
      x = 804 + 8 * k;
      y = x / 2 + prev / 4;
      push(x, -x);
      if (k % 3 == 1) take(y, -y);
      prev = x;
    end
    repeat (20) @(negedge sys_clk);
    chk(40'(outs.size()), 40'h0);
    // bypass with a stalled consumer: two slots then refusal
    wr(`FIR_REG_CTRL, 16'h0800);
    @(posedge sys_clk);
    out_ready <= 1'b0;
    push(20'h7abcd, 20'h80001);
    push(3, 4);
    repeat (3) @(negedge sys_clk);
    chk(40'(in_ready), 40'h0);
    @(posedge sys_clk);
    out_ready <= 1'b1;
    push(5, 6);
    take(20'h7abcd, 20'h80001);
    take(3, 4);
    take(5, 6);
    // three-tap folded filter; history is not touched by bypass
    wr(`FIR_REG_CTRL, 16'h0300);
    do_cmd(fir_pkg::OP_PROGRAM, 3'h0, 16'h0, 7'h02, 1'b1);
    rd_chk(`FIR_REG_OFF, 16'h003f);
    wr(`FIR_REG_MEM, 16'h1000);
    wr(`FIR_REG_MEM, 16'h0800);
    push(400, -400);
    take(731, -731);
    push(800, -800);
    take(611, -611);
    push(1200, -1200);
    take(800, -800);
    // offset moves to 0 while this sample is in its taps: old set wins
    fork
      wr(`FIR_REG_OFF, 16'h0000);
      push(1600, -1600);
    join
    take(1200, -1200);
    // next sample uses 0.25 centre and 0.5 outer from offset 0
    push(2000, -2000);
    take(2000, -2000);
    final_report();
  end
endmodule : testbench
